//--- logic/pmsamp_pkg.sv
// constants, register map and types of the performance monitor
// Notes on behaviour
// - two general counters, three fixed counters; identity reports monitoring version 3
// - every counter is 40 bits; width shown in identity bits 23:16
// - each general counter counts the event code and unit mask of its own select
// - any-thread qualifier bit 21 is stored but never used
// - two off-core response filters qualify event B7H with unit mask 01H or 02H
// - latency mode: counter 0 counts requests, counter 1 adds outstanding cycles
// - only general counter 0 may raise sampling records
// - record holds state after the instruction following the eventing one
// - every record field is 64 bits at consecutive 8-byte offsets
// - flags 00H, pointer 08H, registers 10H-88H, overflow status 90H, eventing pointer B0H, rest reserved
package pmsamp_pkg;
  // ==========================================================
  // widths
  localparam int CTR_W = 40;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 8;
  localparam int NUM_GPR = 16;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_EVTSEL0 = 8'h00;
  localparam logic [7:0] ADDR_EVTSEL1 = 8'h01;
  localparam logic [7:0] ADDR_GPC0 = 8'h02;
  localparam logic [7:0] ADDR_GPC1 = 8'h03;
  localparam logic [7:0] ADDR_FIX0 = 8'h04;
  localparam logic [7:0] ADDR_FIX1 = 8'h05;
  localparam logic [7:0] ADDR_FIX2 = 8'h06;
  localparam logic [7:0] ADDR_FIXCTRL = 8'h07;
  localparam logic [7:0] ADDR_GCTRL = 8'h08;
  localparam logic [7:0] ADDR_GSTATUS = 8'h09;
  localparam logic [7:0] ADDR_IMASK = 8'h0a;
  localparam logic [7:0] ADDR_OFFRSP0 = 8'h0b;
  localparam logic [7:0] ADDR_OFFRSP1 = 8'h0c;
  localparam logic [7:0] ADDR_SAMPEN = 8'h0d;
  localparam logic [7:0] ADDR_SAVEAREA = 8'h0e;
  localparam logic [7:0] ADDR_IDENT = 8'h0f;
  // ==========================================================
  // event select fields
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_UMASK_LSB = 8;
  localparam int SEL_ANYTHR_BIT = 21;
  localparam int SEL_EN_BIT = 22;
  localparam logic [7:0] UMASK_ALL = 8'h00;
  localparam int FIXCTRL_STRIDE = 4;
  // ==========================================================
  // identity fields
  localparam logic [7:0] ID_VERSION = 8'h03;
  localparam logic [7:0] ID_NUM_GP = 8'h02;
  localparam logic [7:0] ID_WIDTH = 8'h28;
  localparam logic [7:0] ID_NUM_FIX = 8'h03;
  localparam int ID_NUM_GP_LSB = 8;
  localparam int ID_WIDTH_LSB = 16;
  localparam int ID_NUM_FIX_LSB = 32;
  // ==========================================================
  // off-core response filter
  localparam logic [7:0] OFFCORE_CODE = 8'hb7;
  localparam logic [7:0] UMASK_RSP0 = 8'h01;
  localparam logic [7:0] UMASK_RSP1 = 8'h02;
  localparam int RSP_REQ_W = 16;
  localparam int RSP_ANY_BIT = 16;
  localparam int RSP_SUP_LSB = 17;
  localparam int RSP_SUP_W = 14;
  localparam int RSP_SNP_LSB = 31;
  localparam int RSP_SNP_W = 7;
  localparam int RSP_LAT_BIT = 38;
  localparam int OUTST_W = 8;
  // ==========================================================
  // sampling-capable event codes
  localparam logic [7:0] EVT_RET_BRANCH = 8'hc4;
  localparam logic [7:0] EVT_MISP_BRANCH = 8'hc5;
  localparam logic [7:0] EVT_MEM_UOPS = 8'h04;
  localparam logic [7:0] EVT_REHABILITATION_QUEUE_EVENT = 8'h03;
  // ==========================================================
  // status bits and record layout
  localparam int ST_GP_LSB = 0;
  localparam int ST_FIX_LSB = 32;
  localparam int ST_REC_BIT = 62;
  localparam int SAMPEN_BIT = 0;
  localparam logic [DATA_W-1:0] FIELD_BYTES = 64'h8;
  localparam int REC_FIELDS = 24;
  localparam logic [4:0] IDX_FLAGS = 5'h00;
  localparam logic [4:0] IDX_IP = 5'h01;
  localparam logic [4:0] IDX_GPR0 = 5'h02;
  localparam logic [4:0] IDX_STATUS = 5'h12;
  localparam logic [4:0] IDX_EVIP = 5'h16;
  localparam logic [4:0] IDX_LAST = 5'h17;
  localparam logic [DATA_W-1:0] REC_BYTES = 64'hc0;
  // ==========================================================
  // sampling sequencer states
  typedef enum logic [3:0] {
    SAMP_IDLE = 4'b0001,
    SAMP_ARMED = 4'b0010,
    SAMP_LAUNCH = 4'b0100,
    SAMP_WRITE = 4'b1000
  } pmsamp_state_t;
endpackage

//--- logic/pmsamp_rec_if.sv
// carrier between the sampling sequencer and the record writer
`timescale 1ns/1ns
interface pmsamp_rec_if;
  import pmsamp_pkg::*;
  logic start;
  logic busy;
  logic [DATA_W-1:0] flags;
  logic [DATA_W-1:0] ip;
  logic [NUM_GPR-1:0][DATA_W-1:0] gpr;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] evIp;
  logic [DATA_W-1:0] base;
  modport src (output start, flags, ip, gpr, status, evIp, base, input busy);
  modport sink (input start, flags, ip, gpr, status, evIp, base, output busy);
endinterface

//--- logic/pmsamp_rec_writer.sv
// writes one sampling record as 64-bit stores
`timescale 1ns/1ns
module pmsamp_rec_writer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // record contents
  pmsamp_rec_if.sink rec,
  // memory store port
  output logic memWrValid,
  output logic [pmsamp_pkg::DATA_W-1:0] memWrAddr,
  output logic [pmsamp_pkg::DATA_W-1:0] memWrData,
  input wire logic memWrReady
);
  import pmsamp_pkg::*;

  logic activeReg;
  logic [4:0] idxReg;
  logic [DATA_W-1:0] addrReg;
  logic [DATA_W-1:0] dataReg;

  // field layout: flags, pointer, 16 registers, status, reserved, eventing pointer
  function automatic logic [DATA_W-1:0] fieldData(input logic [4:0] idx);
    logic [DATA_W-1:0] d;
    d = '0;
    if (idx == IDX_FLAGS) begin
      d = rec.flags;
    end else if (idx == IDX_IP) begin
      d = rec.ip;
    end else if (idx >= IDX_GPR0 && idx < IDX_STATUS) begin
      d = rec.gpr[4'(idx - IDX_GPR0)];
    end else if (idx == IDX_STATUS) begin
      d = rec.status;
    end else if (idx == IDX_EVIP) begin
      d = rec.evIp;
    end
    return d;
  endfunction

  // ==========================================================
  // store sequencing; a stalled store holds address and data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      activeReg <= 1'b0;
      idxReg <= '0;
      addrReg <= '0;
      dataReg <= '0;
    end else if (!activeReg) begin
      if (rec.start) begin
        activeReg <= 1'b1;
        idxReg <= IDX_FLAGS;
        addrReg <= rec.base;
        dataReg <= fieldData(IDX_FLAGS);
      end
    end else if (memWrReady) begin
      if (idxReg == IDX_LAST) begin
        activeReg <= 1'b0;
      end else begin
        idxReg <= idxReg + 5'h01;
        addrReg <= addrReg + FIELD_BYTES;
        dataReg <= fieldData(idxReg + 5'h01);
      end
    end
  end

  assign rec.busy = activeReg;
  assign memWrValid = activeReg;
  assign memWrAddr = addrReg;
  assign memWrData = dataReg;
endmodule

//--- logic/pmsamp_unit.sv
// performance monitor counters with precise sampling records
`timescale 1ns/1ns
module pmsamp_unit (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [pmsamp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pmsamp_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pmsamp_pkg::DATA_W-1:0] regRdata,
  // general event stream, one event per cycle
  input wire logic evValid,
  input wire logic [7:0] evCode,
  input wire logic [7:0] evUmask,
  // fixed event pulses
  input wire logic instRetired,
  input wire logic coreCycle,
  input wire logic refTick,
  // off-core responses
  input wire logic offValid,
  input wire logic [pmsamp_pkg::RSP_REQ_W-1:0] offReqType,
  input wire logic [pmsamp_pkg::RSP_SUP_W-1:0] offSupplier,
  input wire logic [pmsamp_pkg::RSP_SNP_W-1:0] offSnoop,
  input wire logic [pmsamp_pkg::OUTST_W-1:0] offOutstanding,
  // retirement state
  input wire logic retValid,
  input wire logic [pmsamp_pkg::DATA_W-1:0] retIp,
  input wire logic [pmsamp_pkg::DATA_W-1:0] retFlags,
  input wire logic [pmsamp_pkg::NUM_GPR-1:0][pmsamp_pkg::DATA_W-1:0] retGpr,
  // record store port
  output logic memWrValid,
  output logic [pmsamp_pkg::DATA_W-1:0] memWrAddr,
  output logic [pmsamp_pkg::DATA_W-1:0] memWrData,
  input wire logic memWrReady,
  // interrupt
  output logic irq
);
  import pmsamp_pkg::*;

  // ==========================================================
  // declarations
  logic [DATA_W-1:0] evtSel_reg [2];
  logic [CTR_W-1:0] gpCnt_reg [2];
  logic [CTR_W-1:0] fixCnt_reg [3];
  logic [DATA_W-1:0] fixCtrl_reg;
  logic [DATA_W-1:0] gCtrl_reg;
  logic [DATA_W-1:0] status_reg;
  logic [DATA_W-1:0] mask_reg;
  logic [DATA_W-1:0] offRsp_reg [2];
  logic [DATA_W-1:0] sampEn_reg;
  logic [DATA_W-1:0] recPtr_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  pmsamp_state_t state_reg;
  pmsamp_state_t state_next;
  logic [DATA_W-1:0] evIp_reg;
  logic [DATA_W-1:0] snapFlags_reg;
  logic [DATA_W-1:0] snapIp_reg;
  logic [NUM_GPR-1:0][DATA_W-1:0] snapGpr_reg;
  logic [DATA_W-1:0] snapStatus_reg;
  logic [CTR_W-1:0] gpInc [2];
  logic [1:0] gpOvf;
  logic [2:0] fixOvf;
  logic [2:0] fixEv;
  logic latMode;
  logic sampCapable;
  logic recDone;
  logic busyDly_reg;
  logic [DATA_W-1:0] ident;
  pmsamp_rec_if recBus ();

  // ==========================================================
  // helpers
  // plain event match on code and unit mask; zero unit mask takes any sub-event
  function automatic logic selMatch(input logic [DATA_W-1:0] sel);
    logic [7:0] um;
    um = sel[SEL_UMASK_LSB +: 8];
    // the any-thread bit is never looked at: single-thread core
    return evValid && sel[SEL_CODE_LSB +: 8] == evCode &&
      (um == UMASK_ALL || (um & evUmask) != UMASK_ALL);
  endfunction

  // off-core filter: a request bit must match, then any or supplier and snoop
  function automatic logic rspMatch(input logic [DATA_W-1:0] rsp);
    logic reqHit;
    logic supHit;
    logic snpHit;
    reqHit = (rsp[RSP_REQ_W-1:0] & offReqType) != '0;
    supHit = (rsp[RSP_SUP_LSB +: RSP_SUP_W] & offSupplier) != '0;
    snpHit = (rsp[RSP_SNP_LSB +: RSP_SNP_W] & offSnoop) != '0;
    return offValid && reqHit && (rsp[RSP_ANY_BIT] || (supHit && snpHit));
  endfunction

  // counting qualifier for one general counter, plain or off-core
  function automatic logic gpHit(input logic [DATA_W-1:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel[SEL_CODE_LSB +: 8] == OFFCORE_CODE) begin
      if (sel[SEL_UMASK_LSB +: 8] == UMASK_RSP0) begin
        hit = rspMatch(offRsp_reg[0]);
      end else if (sel[SEL_UMASK_LSB +: 8] == UMASK_RSP1) begin
        hit = rspMatch(offRsp_reg[1]);
      end
    end else begin
      hit = selMatch(sel);
    end
    return hit;
  endfunction

  // 40-bit add with carry out as the overflow
  function automatic logic [CTR_W:0] addCnt(input logic [CTR_W-1:0] a,
                                            input logic [CTR_W-1:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  // ==========================================================
  // increments of the general counters
  assign latMode = offRsp_reg[0][RSP_LAT_BIT] &&
    evtSel_reg[1][SEL_CODE_LSB +: 8] == OFFCORE_CODE;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      gpInc[i] = '0;
      if (evtSel_reg[i][SEL_EN_BIT] && gCtrl_reg[ST_GP_LSB + i] && gpHit(evtSel_reg[i])) begin
        gpInc[i] = CTR_W'(1);
      end
    end
    // latency mode: counter 1 sums outstanding requests every cycle
    if (latMode && evtSel_reg[1][SEL_EN_BIT] && gCtrl_reg[ST_GP_LSB + 1]) begin
      gpInc[1] = CTR_W'(offOutstanding);
    end
  end
  assign fixEv = {refTick, coreCycle, instRetired};

  // ==========================================================
  // general counters; a software write wins over a same-cycle count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpCnt_reg[0] <= '0;
      gpCnt_reg[1] <= '0;
      gpOvf <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (regWr && regAddr == ADDR_GPC0 + 8'(i)) begin
          gpCnt_reg[i] <= regWdata[CTR_W-1:0];
          gpOvf[i] <= 1'b0;
        end else begin
          {gpOvf[i], gpCnt_reg[i]} <= addCnt(gpCnt_reg[i], gpInc[i]);
        end
      end
    end
  end

  // ==========================================================
  // fixed counters, each with its own enable nibble
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        fixCnt_reg[i] <= '0;
      end
      fixOvf <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (regWr && regAddr == ADDR_FIX0 + 8'(i)) begin
          fixCnt_reg[i] <= regWdata[CTR_W-1:0];
          fixOvf[i] <= 1'b0;
        end else begin
          {fixOvf[i], fixCnt_reg[i]} <= addCnt(fixCnt_reg[i],
            CTR_W'(fixEv[i] && fixCtrl_reg[i*FIXCTRL_STRIDE] && gCtrl_reg[ST_FIX_LSB + i]));
        end
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evtSel_reg[0] <= '0;
      evtSel_reg[1] <= '0;
      offRsp_reg[0] <= '0;
      offRsp_reg[1] <= '0;
      fixCtrl_reg <= '0;
      gCtrl_reg <= '0;
      mask_reg <= '0;
      sampEn_reg <= '0;
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_EVTSEL0: evtSel_reg[0] <= regWdata;
        ADDR_EVTSEL1: evtSel_reg[1] <= regWdata;
        ADDR_OFFRSP0: offRsp_reg[0] <= regWdata;
        ADDR_OFFRSP1: offRsp_reg[1] <= regWdata;
        ADDR_FIXCTRL: fixCtrl_reg <= regWdata;
        ADDR_GCTRL: gCtrl_reg <= regWdata;
        ADDR_IMASK: mask_reg <= regWdata;
        ADDR_SAMPEN: sampEn_reg <= regWdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // overflow status: read clears, but a new overflow in that cycle survives
  assign recDone = busyDly_reg && !recBus.busy;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
      busyDly_reg <= 1'b0;
    end else begin
      busyDly_reg <= recBus.busy;
      status_reg <= (regRd && regAddr == ADDR_GSTATUS ? '0 : status_reg) |
        (DATA_W'(gpOvf) << ST_GP_LSB) | (DATA_W'(fixOvf) << ST_FIX_LSB) |
        (DATA_W'(recDone) << ST_REC_BIT);
    end
  end
  assign irq = (status_reg & mask_reg) != '0;

  // ==========================================================
  // sampling sequencer, counter 0 only; overflows during a write are dropped
  assign sampCapable = evtSel_reg[0][SEL_CODE_LSB +: 8] inside
    {EVT_RET_BRANCH, EVT_MISP_BRANCH, EVT_MEM_UOPS, EVT_REHABILITATION_QUEUE_EVENT};
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SAMP_IDLE: begin
        if (gpOvf[0] && sampEn_reg[SAMPEN_BIT] && sampCapable) begin
          state_next = SAMP_ARMED;
        end
      end
      SAMP_ARMED: begin
        if (retValid) begin
          state_next = SAMP_LAUNCH;
        end
      end
      SAMP_LAUNCH: state_next = SAMP_WRITE;
      SAMP_WRITE: begin
        if (!recBus.busy) begin
          state_next = SAMP_IDLE;
        end
      end
      default: state_next = SAMP_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SAMP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // snapshot of state; the overflow is seen a cycle after its retirement
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evIp_reg <= '0;
      snapFlags_reg <= '0;
      snapIp_reg <= '0;
      snapGpr_reg <= '0;
      snapStatus_reg <= '0;
    end else begin
      if (retValid && state_reg == SAMP_IDLE) begin
        evIp_reg <= retIp;
      end
      if (retValid && state_reg == SAMP_ARMED) begin
        snapFlags_reg <= retFlags;
        snapIp_reg <= retIp;
        snapGpr_reg <= retGpr;
        snapStatus_reg <= status_reg;
      end
    end
  end

  // ==========================================================
  // record pointer: loaded by software, stepped one record after each write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      recPtr_reg <= '0;
    end else if (regWr && regAddr == ADDR_SAVEAREA) begin
      recPtr_reg <= regWdata;
    end else if (recDone) begin
      recPtr_reg <= recPtr_reg + REC_BYTES;
    end
  end

  // ==========================================================
  // record writer hookup
  assign recBus.start = state_reg == SAMP_LAUNCH;
  assign recBus.flags = snapFlags_reg;
  assign recBus.ip = snapIp_reg;
  assign recBus.gpr = snapGpr_reg;
  assign recBus.status = snapStatus_reg;
  assign recBus.evIp = evIp_reg;
  assign recBus.base = recPtr_reg;

  pmsamp_rec_writer writer (
    .clk(clk),
    .nrst(nrst),
    .rec(recBus),
    .memWrValid(memWrValid),
    .memWrAddr(memWrAddr),
    .memWrData(memWrData),
    .memWrReady(memWrReady)
  );

  // ==========================================================
  // read mux; counters are live, so reads near events can be off by a few
  assign ident = (DATA_W'(ID_VERSION)) | (DATA_W'(ID_NUM_GP) << ID_NUM_GP_LSB) |
    (DATA_W'(ID_WIDTH) << ID_WIDTH_LSB) | (DATA_W'(ID_NUM_FIX) << ID_NUM_FIX_LSB);
  always_comb begin
    rdata_next = '0;
    if (regRd) begin
      unique case (regAddr)
        ADDR_EVTSEL0: rdata_next = evtSel_reg[0];
        ADDR_EVTSEL1: rdata_next = evtSel_reg[1];
        ADDR_GPC0: rdata_next = DATA_W'(gpCnt_reg[0]);
        ADDR_GPC1: rdata_next = DATA_W'(gpCnt_reg[1]);
        ADDR_FIX0: rdata_next = DATA_W'(fixCnt_reg[0]);
        ADDR_FIX1: rdata_next = DATA_W'(fixCnt_reg[1]);
        ADDR_FIX2: rdata_next = DATA_W'(fixCnt_reg[2]);
        ADDR_FIXCTRL: rdata_next = fixCtrl_reg;
        ADDR_GCTRL: rdata_next = gCtrl_reg;
        ADDR_GSTATUS: rdata_next = status_reg;
        ADDR_IMASK: rdata_next = mask_reg;
        ADDR_OFFRSP0: rdata_next = offRsp_reg[0];
        ADDR_OFFRSP1: rdata_next = offRsp_reg[1];
        ADDR_SAMPEN: rdata_next = sampEn_reg;
        ADDR_SAVEAREA: rdata_next = recPtr_reg;
        ADDR_IDENT: rdata_next = ident;
        default: rdata_next = '0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign regRdata = rdata_reg;
endmodule

//--- testbench/pmsamp_unit_assertions.sv
// concurrent checks on the ports of the performance monitor
`timescale 1ns/1ns
module pmsamp_unit_chk
  import pmsamp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [pmsamp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pmsamp_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [pmsamp_pkg::DATA_W-1:0] regRdata,
  // retirement and record stores
  input wire logic retValid,
  input wire logic memWrValid,
  input wire logic [pmsamp_pkg::DATA_W-1:0] memWrAddr,
  input wire logic [pmsamp_pkg::DATA_W-1:0] memWrData,
  input wire logic memWrReady,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // helper logic
  logic [5:0] acceptCnt;
  // accepted stores of the record in flight, cleared while no store waits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acceptCnt <= 6'h0;
    end else if (memWrValid && memWrReady) begin
      acceptCnt <= acceptCnt + 6'h1;
    end else if (!memWrValid) begin
      acceptCnt <= 6'h0;
    end
  end
  sequence storeStall;
    memWrValid && !memWrReady;
  endsequence
  sequence storeTaken;
    memWrValid && memWrReady;
  endsequence
  // ==========================================================
  // assertions
  rdata_idle_a: assert property (!regRd |=> regRdata == 64'h0)
    else $error("read data not zero outside a read answer");
  ident_value_a: assert property (
    regRd && regAddr == ADDR_IDENT |=> regRdata == 64'h0000_0003_0028_0203)
    else $error("identity word wrong");
  ctr_width_a: assert property (
    regRd && (regAddr == ADDR_GPC0 || regAddr == ADDR_GPC1) |=> regRdata[63:40] == 24'h0)
    else $error("counter wider than forty bits");
  store_hold_a: assert property (
    storeStall |=> memWrValid && $stable(memWrAddr) && $stable(memWrData))
    else $error("store changed before acceptance");
  store_step_a: assert property (
    storeTaken |=> !memWrValid || memWrAddr == $past(memWrAddr) + 64'h8)
    else $error("record fields not eight bytes apart");
  store_start_a: assert property ($rose(memWrValid) |-> $past(retValid, 2))
    else $error("record started without a capturing retirement");
  record_len_a: assert property ($fell(memWrValid) |-> acceptCnt == 6'h18)
    else $error("record not twenty four fields long");
  irq_mask_a: assert property (regWr && regAddr == ADDR_IMASK && regWdata == 64'h0 |=> !irq)
    else $error("interrupt high with everything masked");
endmodule

bind pmsamp_unit pmsamp_unit_chk i_chk (.clk(clk), .nrst(nrst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .retValid(retValid), .memWrValid(memWrValid), .memWrAddr(memWrAddr),
  .memWrData(memWrData), .memWrReady(memWrReady), .irq(irq));

//--- testbench/pmsamp_unit_tb_top.sv
// self-checking bench for the performance monitor
`timescale 1ns/1ns
module pmsamp_unit_tb_top;
  import pmsamp_pkg::*;
  logic clk, nrst, regWr, regRd, evValid, instRetired, coreCycle, refTick, offValid;
  logic retValid, memWrValid, memWrReady, irq, seen;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, retIp, retFlags, memWrAddr, memWrData;
  logic [7:0] evCode, evUmask;
  logic [RSP_REQ_W-1:0] offReqType;
  logic [RSP_SUP_W-1:0] offSupplier;
  logic [RSP_SNP_W-1:0] offSnoop;
  logic [OUTST_W-1:0] offOutstanding;
  logic [NUM_GPR-1:0][DATA_W-1:0] retGpr;
  int fail_count, compares, n;
  localparam logic [DATA_W-1:0] MAXC = 64'h0000_00ff_ffff_ffff;
  localparam logic [DATA_W-1:0] BASE = 64'h1000;
  pmsamp_unit i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .evValid(evValid), .evCode(evCode),
    .evUmask(evUmask), .instRetired(instRetired), .coreCycle(coreCycle), .refTick(refTick),
    .offValid(offValid), .offReqType(offReqType), .offSupplier(offSupplier),
    .offSnoop(offSnoop), .offOutstanding(offOutstanding), .retValid(retValid),
    .retIp(retIp), .retFlags(retFlags), .retGpr(retGpr), .memWrValid(memWrValid),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .memWrReady(memWrReady), .irq(irq));
  // ==========================================================
  // shared tasks
  task automatic chk(input string w, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rc(input string w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(w, regRdata, e);
  endtask
  task automatic ev(input logic [7:0] c, input logic [7:0] u, input int k);
    @(posedge clk);
    evValid <= 1'b1;
    evCode <= c;
    evUmask <= u;
    repeat (k) @(posedge clk);
    evValid <= 1'b0;
  endtask
  // expected record field k for the sampling scenario
  function automatic logic [DATA_W-1:0] fexp(input int k);
    if (k == 0) return 64'h246;
    if (k == 1) return 64'hbbb0;
    if (k >= 2 && k < 18) return 64'h100 + 64'(k - 2);
    if (k == 18) return 64'h1;
    if (k == 22) return 64'haaa0;
    return 64'h0;
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_ident;
    wr(ADDR_IDENT, 64'h0);
    rc("ident", ADDR_IDENT, 64'h0000_0003_0028_0203);
    rc("unmapped", 8'h20, 64'h0);
  endtask
  // any-thread bit set on select 0 must change nothing
  task automatic t_count;
    wr(ADDR_GCTRL, 64'h7_0000_0003);
    wr(ADDR_FIXCTRL, 64'h111);
    wr(ADDR_EVTSEL0, 64'h60_412e);
    wr(ADDR_EVTSEL1, 64'h40_0011);
    ev(8'h2e, 8'h41, 3);
    ev(8'h11, 8'h00, 2);
    ev(8'h2e, 8'h02, 1);
    @(posedge clk);
    {refTick, coreCycle, instRetired} <= 3'h7;
    @(posedge clk);
    refTick <= 1'b0;
    @(posedge clk);
    {coreCycle, instRetired} <= 2'h0;
    rc("gpc0", ADDR_GPC0, 64'h3);
    rc("gpc1", ADDR_GPC1, 64'h2);
    rc("fix0", ADDR_FIX0, 64'h2);
    rc("fix1", ADDR_FIX1, 64'h2);
    rc("fix2", ADDR_FIX2, 64'h1);
  endtask
  // counter 0 wraps on a capable event; ready toggles to stall the stores
  task automatic t_sample;
    wr(ADDR_IMASK, 64'h1);
    wr(ADDR_SAVEAREA, BASE);
    wr(ADDR_SAMPEN, 64'h1);
    wr(ADDR_EVTSEL0, 64'h40_00c4);
    wr(ADDR_GPC0, MAXC);
    @(posedge clk);
    evValid <= 1'b1;
    evCode <= EVT_RET_BRANCH;
    evUmask <= 8'h00;
    retValid <= 1'b1;
    retIp <= 64'haaa0;
    @(posedge clk);
    evValid <= 1'b0;
    retValid <= 1'b0;
    repeat (4) @(posedge clk);
    retValid <= 1'b1;
    retIp <= 64'hbbb0;
    retFlags <= 64'h246;
    for (int i = 0; i < NUM_GPR; i++) retGpr[i] <= 64'h100 + 64'(i);
    @(posedge clk);
    retValid <= 1'b0;
    n = 0;
    for (int i = 0; i < 300 && n < 24; i++) begin
      @(posedge clk);
      memWrReady <= ~memWrReady;
      if (memWrValid === 1'b1 && memWrReady) begin
        chk("rec addr", memWrAddr, BASE + 64'(n) * FIELD_BYTES);
        chk("rec data", memWrData, fexp(n));
        n++;
      end
    end
    chk("rec count", 64'(n), 64'h18);
    repeat (2) @(posedge clk);
    memWrReady <= 1'b1;
    chk("irq set", 64'(irq), 64'h1);
    rc("status", ADDR_GSTATUS, 64'h4000_0000_0000_0001);
    chk("irq clear", 64'(irq), 64'h0);
    rc("pointer", ADDR_SAVEAREA, BASE + REC_BYTES);
    wr(ADDR_IMASK, 64'h0);
  endtask
  // counter 1 wraps with sampling enabled and must not write a record
  task automatic t_other;
    wr(ADDR_EVTSEL0, 64'h0);
    wr(ADDR_EVTSEL1, 64'h40_00c4);
    wr(ADDR_GPC1, MAXC);
    seen = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      evValid <= (i < 8);
      retValid <= (i < 8);
      seen = seen | (memWrValid !== 1'b0);
    end
    chk("no record", 64'(seen), 64'h0);
    rc("status1", ADDR_GSTATUS, 64'h2);
    rc("gpc1 wrap", ADDR_GPC1, 64'h7);
  endtask
  task automatic t_latency;
    wr(ADDR_OFFRSP0, 64'h0000_0040_0001_0001);
    wr(ADDR_EVTSEL0, 64'h40_01b7);
    wr(ADDR_EVTSEL1, 64'h40_01b7);
    wr(ADDR_GPC0, 64'h0);
    wr(ADDR_GPC1, 64'h0);
    @(posedge clk);
    offValid <= 1'b1;
    offReqType <= 16'h1;
    offOutstanding <= 8'h5;
    repeat (3) @(posedge clk);
    offValid <= 1'b0;
    offOutstanding <= 8'h0;
    rc("requests", ADDR_GPC0, 64'h3);
    rc("weighted", ADDR_GPC1, 64'hf);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the scenarios need under two hundred cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    {nrst, regWr, regRd, evValid, instRetired, coreCycle, refTick, offValid} = 8'h0;
    {retValid, memWrReady, regAddr, regWdata, evCode, evUmask} = '0;
    {offReqType, offSupplier, offSnoop, offOutstanding, retIp, retFlags} = '0;
    retGpr = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_ident;
    t_count;
    t_sample;
    t_other;
    t_latency;
    report_and_stop;
  end
endmodule
